// File: shared/oasc_pkg.sv
// package of constants and types for the output auto-shutdown unit
//
// Behaviour
// RULE1: overrides hold until first rise after clear
// RULE2: software request bit forces shutdown state
// RULE3: no auto-restart: wait software clear, then rise
// RULE4: auto-restart: hardware clears request when inputs idle
// RULE5: active source resets latches, overrides outputs immediately
// RULE6: enabled sources active low, any one shuts down
// RULE7: separate enable bit for each of eight sources
// RULE8: level sensitive; held while source stays active
// RULE9: one field sets A/C, other sets B/D
// RULE10: four choices: low, high, tri-state, inactive
// RULE11: polarity skips forced levels, applies to inactive
// RULE12: field encoding identical for both output pairs
package oasc_pkg;
    // number of shutdown sources: pin, cmp1..4, logic cell, two timers
    localparam int          OASC_NSRC      = 8;
    // override field codes, shared by both pairs
    localparam logic [1:0]  OASC_OVR_INACT = 2'h0;
    localparam logic [1:0]  OASC_OVR_TRI   = 2'h1;
    localparam logic [1:0]  OASC_OVR_LOW   = 2'h2;
    localparam logic [1:0]  OASC_OVR_HIGH  = 2'h3;
    // source enable bit positions
    localparam int          OASC_SRC_PIN   = 0;
    localparam int          OASC_SRC_CMP1  = 1;
    localparam int          OASC_SRC_CMP4  = 4;
    localparam int          OASC_SRC_LC    = 5;
    localparam int          OASC_SRC_TMRA  = 6;
    localparam int          OASC_SRC_TMRB  = 7;
    // reset values
    localparam logic [7:0]  OASC_SRC_RST   = 8'h00;
    localparam logic [3:0]  OASC_OUT_RST   = 4'h0;
    localparam logic [3:0]  OASC_OE_RST    = 4'h0;
    // shutdown state machine
    typedef enum logic [1:0] {
        OASC_RUN  = 2'b01,
        OASC_SHUT = 2'b10
    } oasc_state_t;
endpackage

// File: shared/oasc_if.sv
// interface carrying the pin stage signals between core and output stage
`timescale 1ns/1ps
interface oasc_if;
    logic [3:0] drv;       // generator drive, already polarity applied
    logic [3:0] pol;       // polarity per output, 1 inverts
    logic [3:0] inact;     // inactive level before polarity
    logic       hold;      // overrides in force
    logic [1:0] sel_ac;    // override code, pair a/c
    logic [1:0] sel_bd;    // override code, pair b/d
    logic [3:0] pin_o;     // registered pin levels
    logic [3:0] pin_oe;    // registered pin enables
    modport core  (output drv, pol, inact, hold, sel_ac, sel_bd,
                   input pin_o, pin_oe);
    modport stage (input drv, pol, inact, hold, sel_ac, sel_bd,
                   output pin_o, pin_oe);
endinterface

// File: rtl/oasc_out_stage.sv
// output stage: applies override levels and registers the pins
`timescale 1ns/1ps
module oasc_out_stage
    import oasc_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // core side
    oasc_if.stage     bus
);
    logic [3:0] o_nxt;   // next pin levels
    logic [3:0] oe_nxt;  // next pin enables
    logic [3:0] o_r;     // registered levels
    logic [3:0] oe_r;    // registered enables

    // pick one override per output; a/c are bits 0,2, b/d bits 1,3
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            logic [1:0] sel;
            sel = (i % 2 == 0) ? bus.sel_ac : bus.sel_bd; // [RULE9] [RULE12]
            o_nxt[i]  = bus.drv[i];
            oe_nxt[i] = 1'b1;
            if (bus.hold) begin
                case (sel) // [RULE10]
                    OASC_OVR_LOW:  o_nxt[i] = 1'b0;   // no polarity [RULE11]
                    OASC_OVR_HIGH: o_nxt[i] = 1'b1;   // no polarity [RULE11]
                    OASC_OVR_TRI: begin
                        o_nxt[i]  = 1'b0;
                        oe_nxt[i] = 1'b0;             // release the pin
                    end
                    default: o_nxt[i] = bus.inact[i] ^ bus.pol[i]; // [RULE11]
                endcase
            end
        end
    end

    // register pins so outputs come from flip-flops
    always_ff @(posedge clk) begin
        if (reset) begin
            o_r  <= OASC_OUT_RST;
            oe_r <= OASC_OE_RST;
        end else begin
            o_r  <= o_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign bus.pin_o  = o_r;
    assign bus.pin_oe = oe_r;
endmodule

// File: rtl/oasc_top.sv
// auto-shutdown control of the complementary output generator
`timescale 1ns/1ps
module oasc_top
    import oasc_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // control bits
    input  wire logic       shutdown_enable,     // auto-shutdown function on
    input  wire logic       auto_restart,        // hardware clears request
    input  wire logic       sw_req_set,          // pulse: software sets request
    input  wire logic       sw_req_clr,          // pulse: software clears it
    input  wire logic [7:0] shutdown_source_select_reg, // source enables
    input  wire logic [1:0] override_level_pair_ac,
    input  wire logic [1:0] override_level_pair_bd,
    input  wire logic [3:0] polarity,            // 1 inverts output
    // shutdown sources, active low
    input  wire logic       fault_pin_n,
    input  wire logic [3:0] cmp_n,
    input  wire logic       logic_cell_n,
    input  wire logic [1:0] timer_n,
    // generator events that steer the drive
    input  wire logic       rise_evt,            // pulse: rising event
    input  wire logic       fall_evt,            // pulse: falling event
    // status
    output logic            shutdown_request_bit,
    output logic            shutdown_active,
    // generator outputs a..d as pins
    output logic            gen_output_a,
    output logic            gen_output_b,
    output logic            gen_output_c,
    output logic            gen_output_d,
    output logic [3:0]      gen_output_oe
);
    oasc_if                 pin_if ();           // core to output stage
    oasc_state_t            st_r;                // shutdown state
    oasc_state_t            st_nxt;
    logic                   req_r;               // software request bit
    logic                   req_nxt;
    logic                   drv_r;               // output drive latch
    logic                   drv_nxt;
    logic                   sta_r;               // status flop
    logic [OASC_NSRC-1:0]   src_act;             // active sources
    logic                   ext_shut;            // any enabled source low

    // gather sources; low level means active, gated by its enable
    always_comb begin
        src_act[OASC_SRC_PIN]              = ~fault_pin_n;    // [RULE6]
        src_act[OASC_SRC_CMP4:OASC_SRC_CMP1] = ~cmp_n;
        src_act[OASC_SRC_LC]               = ~logic_cell_n;
        src_act[OASC_SRC_TMRA]             = ~timer_n[0];
        src_act[OASC_SRC_TMRB]             = ~timer_n[1];
        // one enable per source [RULE7]; any one suffices [RULE6]
        ext_shut = shutdown_enable
                 & |(src_act & shutdown_source_select_reg);
    end

    // request bit and shutdown state; level sensitive by construction
    always_comb begin
        req_nxt = req_r;
        st_nxt  = st_r;
        if (!shutdown_enable) begin
            // disabling the function is the only escape from a fault
            req_nxt = 1'b0;                              // [RULE8]
        end else begin
            if (sw_req_clr)
                req_nxt = 1'b0;
            if (auto_restart && !ext_shut)
                req_nxt = 1'b0;                          // [RULE4]
            // set wins over any clear in the same cycle
            if (sw_req_set || ext_shut)
                req_nxt = 1'b1;                          // [RULE2] [RULE8]
        end
        case (st_r)
            OASC_RUN: begin
                if (req_nxt)
                    st_nxt = OASC_SHUT;                  // [RULE2] [RULE5]
            end
            OASC_SHUT: begin
                // leave only on a rise once cleared [RULE1] [RULE3] [RULE4]
                if (!req_r && !req_nxt && rise_evt)
                    st_nxt = OASC_RUN;
            end
            default: st_nxt = OASC_SHUT;
        endcase
    end

    // request and state registers
    always_ff @(posedge clk) begin
        if (reset) begin
            st_r  <= OASC_RUN;
            req_r <= 1'b0;
            sta_r <= 1'b0;
        end else begin
            st_r  <= st_nxt;
            req_r <= req_nxt;
            sta_r <= (st_nxt == OASC_SHUT);
        end
    end

    // drive latch: set on rise, cleared on fall or while the next state is shutdown
    always_comb begin
        drv_nxt = drv_r;
        if (fall_evt)
            drv_nxt = 1'b0;
        else if (rise_evt)
            drv_nxt = 1'b1;
        if (st_nxt == OASC_SHUT)
            drv_nxt = 1'b0;                              // [RULE5]
    end

    // drive latch register
    always_ff @(posedge clk) begin
        if (reset)
            drv_r <= 1'b0;
        else
            drv_r <= drv_nxt;
    end

    // complementary drive: a,c follow latch, b,d the opposite
    always_comb begin
        pin_if.inact  = 4'hA;               // latch reset: b,d active
        // next latch value: an event reaches the pins one cycle later,
        // the same delay as an override, so a release shows the new drive
        pin_if.drv    = {~drv_nxt, drv_nxt, ~drv_nxt, drv_nxt} ^ polarity;
        pin_if.pol    = polarity;
        // override applied the same cycle the next state goes to shut
        pin_if.hold   = (st_nxt == OASC_SHUT);           // [RULE5] [RULE1]
        pin_if.sel_ac = override_level_pair_ac;          // [RULE9]
        pin_if.sel_bd = override_level_pair_bd;
    end

    oasc_out_stage u_stage (
        .clk   (clk),
        .reset (reset),
        .bus   (pin_if)
    );

    assign shutdown_request_bit = req_r;
    assign shutdown_active      = sta_r;
    assign gen_output_a         = pin_if.pin_o[0];
    assign gen_output_b         = pin_if.pin_o[1];
    assign gen_output_c         = pin_if.pin_o[2];
    assign gen_output_d         = pin_if.pin_o[3];
    assign gen_output_oe        = pin_if.pin_oe;
endmodule

// File: verif/oasc_src_model.sv
// model of the active-low shutdown sources around the unit
`timescale 1ns/1ps
module oasc_src_model (
    // trip per source, in enable-register bit order
    input  wire logic [7:0] trip,
    // level sources, low while tripped
    output logic            fault_pin_n,
    output logic [3:0]      cmp_n,
    output logic            logic_cell_n,
    output logic [1:0]      timer_n
);
    // plain levels with no filtering: a fault may last a single cycle
    assign {timer_n, logic_cell_n, cmp_n, fault_pin_n} = ~trip;
endmodule

// File: verif/oasc_properties.sv
// checker of the auto-shutdown unit, bound to its top
`timescale 1ns/1ps
module oasc_properties
    import oasc_pkg::*;
(
    // every port of the unit, watched only
    input wire logic       clk, reset, shutdown_enable, auto_restart,
    input wire logic       sw_req_set, sw_req_clr, fault_pin_n, logic_cell_n,
    input wire logic [7:0] shutdown_source_select_reg,
    input wire logic [1:0] override_level_pair_ac, override_level_pair_bd,
    input wire logic [1:0] timer_n,
    input wire logic [3:0] polarity, cmp_n, gen_output_oe,
    input wire logic       rise_evt, fall_evt, shutdown_request_bit,
    input wire logic       shutdown_active, gen_output_a, gen_output_b,
    input wire logic       gen_output_c, gen_output_d
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // some enabled source is low
    wire act = shutdown_enable && |(shutdown_source_select_reg &
        ~{timer_n, logic_cell_n, cmp_n, fault_pin_n});
    // override settled: two cycles in shutdown on an unchanged field
    sequence s_held(f);
        shutdown_active && $past(shutdown_active) && $stable(f);
    endsequence
    // rise with the clear already visible and nothing re-arming
    sequence s_release;
        !shutdown_request_bit && rise_evt && !act && !sw_req_set;
    endsequence
    chk_src_shut: assert property (
        act |=> shutdown_request_bit && shutdown_active)
        else $error("enabled source low gave no shutdown");
    chk_sw_set: assert property (
        shutdown_enable && sw_req_set |=> shutdown_request_bit)
        else $error("software set gave no request");
    chk_hold_out: assert property (
        shutdown_active && !rise_evt |=> shutdown_active)
        else $error("shutdown left without rising event");
    chk_manual_hold: assert property (
        shutdown_enable && !auto_restart && shutdown_request_bit &&
        !sw_req_clr |=> shutdown_request_bit)
        else $error("request dropped without clear");
    chk_auto_clear: assert property (
        shutdown_enable && auto_restart && !act && !sw_req_set
        |=> !shutdown_request_bit)
        else $error("auto restart kept the request");
    chk_rise_release: assert property (
        s_release |=> !shutdown_active)
        else $error("rise after clear did not release");
    chk_ovr_low: assert property (
        s_held(override_level_pair_ac) ##0
        override_level_pair_ac == OASC_OVR_LOW |-> gen_output_oe[0] &&
        gen_output_oe[2] && !gen_output_a && !gen_output_c)
        else $error("pair a/c not forced low");
    chk_ovr_high: assert property (
        s_held(override_level_pair_bd) ##0
        override_level_pair_bd == OASC_OVR_HIGH |-> gen_output_oe[1] &&
        gen_output_oe[3] && gen_output_b && gen_output_d)
        else $error("pair b/d not forced high");
endmodule
bind oasc_top oasc_properties i_chk (.*);

// File: verif/oasc_top_tb.sv
// self-checking bench of the auto-shutdown unit
`timescale 1ns/1ps
module oasc_top_tb;
    import oasc_pkg::*;
    // bench drives, source levels and unit outputs
    logic       clk = 0, reset = 1, en = 0, ar = 0, set = 0, clr = 0;
    logic       rise = 0, fall = 0, pin_n, lc_n, req, act, a, b, c, d;
    logic [7:0] sel = 0, trip = 0;
    logic [3:0] pol = 0, cmp_n, oe;
    logic [1:0] ac = 0, bd = 0, tmr_n;
    int         err_total = 0, n_checks = 0, seed = 32'hA776, k;
    wire  [8:0] seen = {act, oe, d, c, b, a};
    oasc_src_model i_oasc_src_model (.trip(trip), .fault_pin_n(pin_n),
        .cmp_n(cmp_n), .logic_cell_n(lc_n), .timer_n(tmr_n));
    oasc_top i_oasc_top (.clk(clk), .reset(reset), .shutdown_enable(en),
        .auto_restart(ar), .sw_req_set(set), .sw_req_clr(clr),
        .shutdown_source_select_reg(sel), .override_level_pair_ac(ac),
        .override_level_pair_bd(bd), .polarity(pol), .fault_pin_n(pin_n),
        .cmp_n(cmp_n), .logic_cell_n(lc_n), .timer_n(tmr_n),
        .rise_evt(rise), .fall_evt(fall), .shutdown_request_bit(req),
        .shutdown_active(act), .gen_output_a(a), .gen_output_b(b),
        .gen_output_c(c), .gen_output_d(d), .gen_output_oe(oe));
    initial forever #2.5 clk = ~clk;
    // expected active flag, enables and levels while overridden
    function automatic logic [8:0] ovr();
        logic [1:0] f;
        ovr[8] = 1;
        for (int i = 0; i < 4; i++) begin
            f = i[0] ? bd : ac;
            ovr[i+4] = f != OASC_OVR_TRI;
            ovr[i] = f == OASC_OVR_HIGH || f == OASC_OVR_INACT && i[0] ^ pol[i];
        end
    endfunction
    // one counted comparison, mismatch reported at once
    task automatic chk(string nm, logic [8:0] exp, logic [8:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // set, clear, rise for one cycle; held until the next call ends them
    task automatic cyc(logic [2:0] p);
        {set, clr, rise} = p;
        @(negedge clk);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog: about twenty times the expected run
    initial begin
        repeat (2000) @(posedge clk);
        err_total++;
        results;
    end
    initial begin
        repeat (5) cyc(0);
        reset = 0;
        en = 1;
        for (k = 0; k < 16; k++) begin
            // each code pair, one enabled source, the others low but masked
            {bd, ac} = k[3:0];
            {pol, fall} = 5'($random(seed));
            ar = k[0];
            sel = 8'h01 << k[2:0];
            trip = ~sel;
            cyc(0);
            chk("masked", 0, act);
            trip = sel | (8'($random(seed)) & ~sel);
            cyc(0);
            chk("trip", ovr(), seen);
            trip = 0;
            fall = 0;
            cyc(0);
            chk("restart", !ar, req);
            // a rise together with the clear must not release
            if (!ar) cyc(3'b011);
            chk("held", ovr(), seen);
            chk("cleared", 0, req);
            cyc(3'b001);
            chk("released", {1'b0, 4'hF, 4'h5 ^ pol}, seen);
            // a falling event gives the same levels as the inactive choice
            fall = 1;
            cyc(0);
            chk("fall", {1'b0, 4'hF, 4'hA ^ pol}, seen);
            $display("test %0d done, mismatches %0d", k, err_total);
        end
        // software request, then a clear refused while a source is low
        sel = 8'hFF;
        ar = 0;
        cyc(3'b100);
        chk("sw set", 3, {req, act});
        trip = 8'h20;
        cyc(3'b010);
        chk("clr refused", 1, req);
        en = 0;
        cyc(0);
        chk("disabled", 0, req);
        trip = 0;
        en = 1;
        cyc(3'b001);
        chk("sw released", 0, act);
        $display("software test done, mismatches %0d", err_total);
        results;
    end
endmodule
